// [inc/psc_cfg.svh]
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// Widths
`define PSC_CMD_W          8
`define PSC_RESP_W         24
`define PSC_WORD_W         16
`define PSC_WORDS          8
`define PSC_SYNC_W         5

// Command codes and field layout
`define PSC_CMD_RESET      8'h1E
`define PSC_CMD_ADC_READ   8'h00
`define PSC_CALIBRATION_MEMORY_MASK      8'hF1
`define PSC_CALIBRATION_MEMORY_BASE      8'hA0
`define PSC_CONV_MASK      8'hE1
`define PSC_CONV_BASE      8'h40
`define PSC_TEMP_BIT       4
`define PSC_FIELD_MSB      3
`define PSC_FIELD_LSB      1
`define PSC_RATIO_MAX      3'h4
`define PSC_CALIBRATION_MEMORY_PAD       8'h00

// Two-wire address, upper six bits
`define PSC_ADDR_HI        6'h3B

// Serial counters
`define PSC_SPI_LAST_CMD   6'h07
`define PSC_SPI_RESP_START 6'h08
`define PSC_SPI_CNT_MAX    6'h20
`define PSC_SPI_IDX_TOP    6'h1F
`define PSC_I2C_BYTE_BITS  4'h8

// Synchroniser bit positions
`define PSC_SY_SCL         0
`define PSC_SY_SDA         1
`define PSC_SY_SEL         2
`define PSC_SY_PS          3
`define PSC_SY_TGL         4

// Timing: base conversion time, doubled per ratio step
`define PSC_CLK_PERIOD_PS  10000
`define PSC_CONV_BASE_NS   500000
`define PSC_CONV_BASE_CYC  ((`PSC_CONV_BASE_NS * 1000 + `PSC_CLK_PERIOD_PS - 1) / `PSC_CLK_PERIOD_PS)
`define PSC_CONV_CNT_W     24

`endif

// [inc/psc_pkg.sv]
`include "psc_cfg.svh"

package psc_pkg;

  // Two-wire engine states
  typedef enum logic [5:0] {
    PSC_I2C_IDLE  = 6'h01,
    PSC_I2C_ADDR  = 6'h02,
    PSC_I2C_WRITE = 6'h04,
    PSC_I2C_ACK   = 6'h08,
    PSC_I2C_READ  = 6'h10,
    PSC_I2C_HACK  = 6'h20
  } psc_i2c_state_t;

  typedef logic [`PSC_CMD_W-1:0]  psc_cmd_t;
  typedef logic [`PSC_RESP_W-1:0] psc_resp_t;
  typedef logic [`PSC_WORD_W-1:0] psc_word_t;

  // Defined conversion code with a ratio index in range
  function automatic logic psc_is_conv(input psc_cmd_t b);
    psc_is_conv = ((b & `PSC_CONV_MASK) == `PSC_CONV_BASE) &&
                  (b[`PSC_FIELD_MSB:`PSC_FIELD_LSB] <= `PSC_RATIO_MAX);
  endfunction : psc_is_conv

  function automatic logic psc_is_calibration_memory(input psc_cmd_t b);
    psc_is_calibration_memory = ((b & `PSC_CALIBRATION_MEMORY_MASK) == `PSC_CALIBRATION_MEMORY_BASE);
  endfunction : psc_is_calibration_memory

endpackage : psc_pkg

// [inc/psc_conv_if.sv]
`timescale 1ns/1ps

interface psc_conv_if;
  logic                       start;
  logic                       temp_sel;
  logic [2:0]                 ratio;
  logic                       read_hit;
  logic                       abort;
  logic                       busy;
  logic [`PSC_RESP_W-1:0]     result;

  modport ctl  (output start, temp_sel, ratio, read_hit, abort, input busy, result);
  modport core (input start, temp_sel, ratio, read_hit, abort, output busy, result);
endinterface : psc_conv_if

// [design/psc_conv.sv]
`timescale 1ns/1ps

module psc_conv
  import psc_pkg::*;
#(
  parameter int CONV_BASE_CYC = `PSC_CONV_BASE_CYC
) (
  // Clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_resetn,
  // Command side
  psc_conv_if.core                    cif,
  // Analogue front end samples
  input  wire logic [`PSC_RESP_W-1:0] i_raw_pressure_sample,
  input  wire logic [`PSC_RESP_W-1:0] i_raw_temperature_sample
);

  logic [`PSC_CONV_CNT_W-1:0] cnt;
  logic                       temp_q;
  logic                       corrupt;
  logic [`PSC_RESP_W-1:0]     result;
  logic                       busy;

  // Duration doubles with each ratio step
  wire [`PSC_CONV_CNT_W-1:0] dur = `PSC_CONV_CNT_W'(CONV_BASE_CYC) << cif.ratio;
  wire                       done = busy && (cnt == `PSC_CONV_CNT_W'(1));
  wire [`PSC_RESP_W-1:0]     sample = temp_q ? i_raw_temperature_sample : i_raw_pressure_sample;

  // Result is zero unless a conversion finished since the last read
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy    <= 1'b0;
      cnt     <= '0;
      temp_q  <= 1'b0;
      corrupt <= 1'b0;
      result  <= '0;
    end else if (cif.abort) begin
      busy    <= 1'b0;
      result  <= '0;
      corrupt <= 1'b0;
    end else if (cif.start) begin
      busy    <= 1'b1;
      cnt     <= dur;
      temp_q  <= cif.temp_sel;
      corrupt <= busy;
      result  <= '0;
    end else begin
      if (cif.read_hit) begin
        result <= '0;
      end
      if (cif.read_hit && busy) begin
        corrupt <= 1'b1;
      end
      if (busy) begin
        cnt <= cnt - `PSC_CONV_CNT_W'(1);
      end
      if (done) begin
        busy   <= 1'b0;
        // Corrupted result is delivered inverted, never silently correct
        result <= (corrupt || cif.read_hit) ? ~sample : sample;
      end
    end
  end

  assign cif.busy   = busy;
  assign cif.result = result;

endmodule : psc_conv

// [design/psc_top.sv]
`timescale 1ns/1ps

// Summary of operation
// - Each command is one byte; every received byte is decoded whole.
// - Result read returns 24 bits, most significant bit first.
// - Calibration read returns one 16-bit word, most significant bit first.
// - Calibration read codes 0xA0 to 0xAE carry a three-bit word address.
// - Code 0x1E reloads calibration words, aborts any conversion and clears the result; ratio and temperature select status keep their values.
// - Conversion codes start pressure or temperature conversion, temperature bit selects.
// - Pressure codes 0x40 to 0x48 select ratios 256 to 4096.
// - Temperature codes 0x50 to 0x58 select the same ratios.
// - Result read 0x00 returns zero without a fresh finished conversion.
// - Result read during conversion returns zero and corrupts that conversion.
// - Select may rise during conversion; conversion continues, result is held.
// - Calibration memory holds eight 16-bit words.
// - Two-wire address is 111011 plus inverted select pin.
// - Two-wire reset command is accepted at any moment.
// - Two-wire calibration read is a write transaction then a read transaction.
// - Two-wire device stays busy until an accepted conversion finishes or a reset command aborts it.
// - Two-wire result read is 24 bits with acknowledge after each byte.
// - Calibration contents carry a 4-bit CRC for host checking.
// - Protocol select low means SPI, high means two-wire.
// - SPI works in clock mode 0 and mode 3.
module psc_top
  import psc_pkg::*;
#(
  parameter int CONV_BASE_CYC = `PSC_CONV_BASE_CYC
) (
  // System clock and reset
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_resetn,
  // Serial link pins
  input  wire logic                                i_link_sclk,
  input  wire logic                                i_select_pin,
  input  wire logic                                i_protocol_select_pin,
  input  wire logic                                i_serial_in_pin,
  output logic                                     o_serial_out_pin,
  output logic                                     o_serial_out_oe,
  // Two-wire data pin
  input  wire logic                                i_sda,
  output logic                                     o_sda_out,
  output logic                                     o_sda_oe,
  // Calibration store and front end
  input  wire logic [`PSC_WORDS*`PSC_WORD_W-1:0]   i_cal_image,
  input  wire logic [`PSC_RESP_W-1:0]              i_raw_pressure_sample,
  input  wire logic [`PSC_RESP_W-1:0]              i_raw_temperature_sample,
  // Status
  output logic                                     o_conv_busy,
  output logic                                     o_conv_temp_sel,
  output logic [2:0]                               o_oversampling_ratio
);

  psc_conv_if cif ();

  // ------------------------------------------------------------------
  // Shared decode state (system domain)
  // ------------------------------------------------------------------
  psc_word_t calibration_memory [0:`PSC_WORDS-1];
  psc_resp_t rd_word;

  // ------------------------------------------------------------------
  // SPI side, clocked by the link clock; select high ends the frame
  // ------------------------------------------------------------------
  logic [5:0] spi_cnt;
  logic [6:0] spi_sh;
  psc_cmd_t   spi_cmd;
  logic       spi_tgl;
  psc_resp_t  spi_resp;
  logic       spi_out;

  wire       spi_clr  = i_select_pin | ~i_resetn;
  wire psc_cmd_t spi_byte = {spi_sh, i_serial_in_pin};
  wire [2:0] spi_addr = spi_byte[`PSC_FIELD_MSB:`PSC_FIELD_LSB];
  wire [4:0] spi_idx  = 5'(`PSC_SPI_IDX_TOP - spi_cnt);
  // Response picked at the eighth rising edge; system words are quasi-static here
  wire psc_resp_t spi_resp_sel =
    (spi_byte == `PSC_CMD_ADC_READ) ? cif.result :
    psc_is_calibration_memory(spi_byte) ? {calibration_memory[spi_addr], `PSC_CALIBRATION_MEMORY_PAD} : '0;

  // Bit counter and input shifter, sampled on rising edge in both modes
  always_ff @(posedge i_link_sclk or posedge spi_clr) begin
    if (spi_clr) begin
      spi_cnt <= '0;
      spi_sh  <= '0;
    end else begin
      spi_sh <= spi_byte[6:0];
      if (spi_cnt != `PSC_SPI_CNT_MAX) begin
        spi_cnt <= spi_cnt + 6'h01;
      end
    end
  end

  // Command capture survives select rising, so a running conversion is kept
  always_ff @(posedge i_link_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      spi_cmd  <= '0;
      spi_tgl  <= 1'b0;
      spi_resp <= '0;
    end else if (spi_cnt == `PSC_SPI_LAST_CMD) begin
      spi_cmd  <= spi_byte;
      spi_tgl  <= ~spi_tgl;
      spi_resp <= spi_resp_sel;
    end
  end

  // Output bit changes on the falling edge, valid before the next rising
  always_ff @(negedge i_link_sclk or posedge spi_clr) begin
    if (spi_clr) begin
      spi_out <= 1'b0;
    end else if (spi_cnt >= `PSC_SPI_RESP_START && spi_cnt != `PSC_SPI_CNT_MAX) begin
      spi_out <= spi_resp[spi_idx];
    end else begin
      spi_out <= 1'b0;
    end
  end

  assign o_serial_out_pin = spi_out;
  assign o_serial_out_oe  = ~i_protocol_select_pin & ~i_select_pin;

  // ------------------------------------------------------------------
  // Pin synchronisers: three stages, filtered value moves when 2 and 3 agree
  // ------------------------------------------------------------------
  logic [`PSC_SYNC_W-1:0] sy1;
  logic [`PSC_SYNC_W-1:0] sy2;
  logic [`PSC_SYNC_W-1:0] sy3;
  logic [`PSC_SYNC_W-1:0] filt;
  logic [`PSC_SYNC_W-1:0] prev;

  wire [`PSC_SYNC_W-1:0] sy_in = {spi_tgl, i_protocol_select_pin, i_select_pin, i_sda,
                                  i_link_sclk};

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sy1  <= '0;
      sy2  <= '0;
      sy3  <= '0;
      filt <= '0;
      prev <= '0;
    end else begin
      sy1  <= sy_in;
      sy2  <= sy1;
      sy3  <= sy2;
      filt <= (sy2 & sy3) | (filt & (sy2 | sy3));
      prev <= filt;
    end
  end

  wire mode_i2c = filt[`PSC_SY_PS];
  wire scl_f    = filt[`PSC_SY_SCL];
  wire sda_f    = filt[`PSC_SY_SDA];
  wire scl_rise = scl_f & ~prev[`PSC_SY_SCL];
  wire scl_fall = ~scl_f & prev[`PSC_SY_SCL];
  wire scl_held = scl_f & prev[`PSC_SY_SCL];
  wire i2c_start = scl_held & prev[`PSC_SY_SDA] & ~sda_f;
  wire i2c_stop  = scl_held & ~prev[`PSC_SY_SDA] & sda_f;
  wire spi_ev    = (filt[`PSC_SY_TGL] ^ prev[`PSC_SY_TGL]) & ~mode_i2c;
  // Own address: fixed upper bits, inverted select as the last bit
  wire [6:0] own_addr = {`PSC_ADDR_HI, ~filt[`PSC_SY_SEL]};

  // ------------------------------------------------------------------
  // Two-wire engine (system domain, oversampled pins)
  // ------------------------------------------------------------------
  psc_i2c_state_t i2c_st;
  logic [3:0]     i2c_bits;
  psc_cmd_t       i2c_sh;
  logic           i2c_rw;
  logic           i2c_ack;
  logic           i2c_nack;
  psc_resp_t      i2c_tx;
  logic           sda_oe;
  logic           i2c_ev;

  wire byte_full  = (i2c_bits == `PSC_I2C_BYTE_BITS);
  wire addr_match = (i2c_sh[7:1] == own_addr);
  // Conversion bytes are refused while busy; reset always passes
  wire wr_accept  = ~(cif.busy & psc_is_conv(i2c_sh));

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      i2c_st   <= PSC_I2C_IDLE;
      i2c_bits <= '0;
      i2c_sh   <= '0;
      i2c_rw   <= 1'b0;
      i2c_ack  <= 1'b0;
      i2c_nack <= 1'b0;
      i2c_tx   <= '0;
      sda_oe   <= 1'b0;
      i2c_ev   <= 1'b0;
    end else begin
      i2c_ev <= 1'b0;
      if (!mode_i2c || i2c_stop) begin
        i2c_st <= PSC_I2C_IDLE;
        sda_oe <= 1'b0;
      end else if (i2c_start) begin
        // START always frees the data line, clearing any stuck acknowledge
        i2c_st   <= PSC_I2C_ADDR;
        i2c_bits <= '0;
        sda_oe   <= 1'b0;
      end else begin
        case (i2c_st)
          PSC_I2C_ADDR, PSC_I2C_WRITE: begin
            if (scl_rise) begin
              i2c_sh   <= {i2c_sh[6:0], sda_f};
              i2c_bits <= i2c_bits + 4'h1;
            end else if (scl_fall && byte_full) begin
              if (i2c_st == PSC_I2C_ADDR) begin
                i2c_rw  <= i2c_sh[0];
                i2c_ack <= addr_match;
                i2c_tx  <= rd_word;
                sda_oe  <= addr_match;
                i2c_st  <= addr_match ? PSC_I2C_ACK : PSC_I2C_IDLE;
              end else begin
                i2c_rw  <= 1'b0;
                i2c_ack <= wr_accept;
                i2c_ev  <= wr_accept;
                sda_oe  <= wr_accept;
                i2c_st  <= wr_accept ? PSC_I2C_ACK : PSC_I2C_IDLE;
              end
            end
          end
          PSC_I2C_ACK: begin
            if (scl_fall) begin
              i2c_bits <= '0;
              sda_oe   <= i2c_rw & ~i2c_tx[`PSC_RESP_W-1];
              i2c_st   <= i2c_rw ? PSC_I2C_READ : PSC_I2C_WRITE;
            end
          end
          PSC_I2C_READ: begin
            if (scl_rise) begin
              i2c_bits <= i2c_bits + 4'h1;
            end else if (scl_fall) begin
              i2c_tx <= {i2c_tx[`PSC_RESP_W-2:0], 1'b0};
              sda_oe <= ~byte_full & ~i2c_tx[`PSC_RESP_W-2];
              if (byte_full) begin
                i2c_st <= PSC_I2C_HACK;
              end
            end
          end
          PSC_I2C_HACK: begin
            if (scl_rise) begin
              i2c_nack <= sda_f;
            end else if (scl_fall) begin
              // Host acknowledge after every byte; a NACK ends the answer
              i2c_bits <= '0;
              sda_oe   <= ~i2c_nack & ~i2c_tx[`PSC_RESP_W-1];
              i2c_st   <= i2c_nack ? PSC_I2C_IDLE : PSC_I2C_READ;
            end
          end
          PSC_I2C_IDLE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            i2c_st <= PSC_I2C_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe  = sda_oe;

  // ------------------------------------------------------------------
  // Command decode, shared by both protocols
  // ------------------------------------------------------------------
  wire       cmd_ev   = mode_i2c ? i2c_ev : spi_ev;
  wire psc_cmd_t cmd  = mode_i2c ? i2c_sh : spi_cmd;
  wire       dec_rst  = cmd_ev && (cmd == `PSC_CMD_RESET);
  wire       dec_read = cmd_ev && (cmd == `PSC_CMD_ADC_READ);
  wire       dec_calibration_memory = cmd_ev && psc_is_calibration_memory(cmd);
  wire       dec_conv = cmd_ev && psc_is_conv(cmd);
  wire [2:0] cmd_fld  = cmd[`PSC_FIELD_MSB:`PSC_FIELD_LSB];
  // Any other byte matches nothing and leaves all state untouched

  // Conversion control; a running conversion survives select release
  assign cif.start    = dec_conv;
  assign cif.temp_sel = cmd[`PSC_TEMP_BIT];
  assign cif.ratio    = cmd_fld;
  assign cif.read_hit = dec_read;
  assign cif.abort    = dec_rst;

  // Calibration words clear to zero on hardware reset and reload from the store on the reset command; word 7 carries CRC
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < `PSC_WORDS; k++) begin
        calibration_memory[k] <= '0;
      end
    end else if (dec_rst) begin
      for (int k = 0; k < `PSC_WORDS; k++) begin
        calibration_memory[k] <= i_cal_image[k*`PSC_WORD_W +: `PSC_WORD_W];
      end
    end
  end

  // Word handed to the next two-wire read transaction
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_word <= '0;
    end else if (dec_rst) begin
      rd_word <= '0;
    end else if (dec_read) begin
      rd_word <= cif.result;
    end else if (dec_calibration_memory) begin
      rd_word <= {calibration_memory[cmd_fld], `PSC_CALIBRATION_MEMORY_PAD};
    end
  end

  psc_conv #(
    .CONV_BASE_CYC (CONV_BASE_CYC)
  ) u_conv (
    .i_sys_clk                (i_sys_clk),
    .i_resetn                 (i_resetn),
    .cif                      (cif),
    .i_raw_pressure_sample    (i_raw_pressure_sample),
    .i_raw_temperature_sample (i_raw_temperature_sample)
  );

  // Status straight from conversion flip-flops and decode
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_conv_temp_sel      <= 1'b0;
      o_oversampling_ratio <= '0;
    end else if (dec_conv) begin
      o_conv_temp_sel      <= cmd[`PSC_TEMP_BIT];
      o_oversampling_ratio <= cmd_fld;
    end
  end

  assign o_conv_busy = cif.busy;

endmodule : psc_top

// [test/psc_top_asserts.sv]
`timescale 1ns/1ps

module psc_top_asserts #(
  parameter int CONV_BASE_CYC = 100
) (
  // Clock and reset
  input wire logic       i_sys_clk,
  input wire logic       i_resetn,
  // Pins
  input wire logic       i_select_pin,
  input wire logic       i_protocol_select_pin,
  input wire logic       o_serial_out_oe,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  // Status
  input wire logic       o_conv_busy,
  input wire logic       o_conv_temp_sel,
  input wire logic [2:0] o_oversampling_ratio
);
  logic [31:0] busy_cnt;

  // Length of the running conversion, kept apart from the design's own timer
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_cnt <= 32'h0;
    end else begin
      busy_cnt <= o_conv_busy ? busy_cnt + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  a_oe_follows_pins: assert property (
    o_serial_out_oe == (!i_protocol_select_pin && !i_select_pin))
    else $error("serial out enable does not follow the pins");
  a_sda_open_drain: assert property (o_sda_out == 1'b0)
    else $error("data pin driven high");
  a_sda_quiet_spi: assert property (
    !i_protocol_select_pin && $past(!i_protocol_select_pin) |-> !o_sda_oe)
    else $error("two-wire pin pulled in serial mode");
  a_ratio_in_range: assert property (o_conv_busy |-> o_oversampling_ratio <= 3'h4)
    else $error("ratio index out of range");
  a_busy_max_len: assert property (o_conv_busy |-> busy_cnt <= (CONV_BASE_CYC << 4) + 8)
    else $error("conversion runs too long");
  a_busy_min_len: assert property ($fell(o_conv_busy) |-> busy_cnt >= CONV_BASE_CYC - 1)
    else $error("conversion ends too early");
  a_setup_held: assert property (
    o_conv_busy && $past(o_conv_busy) |->
      $stable(o_conv_temp_sel) && $stable(o_oversampling_ratio))
    else $error("conversion setup changed while busy");
  a_setup_starts: assert property (
    $changed(o_oversampling_ratio) || $changed(o_conv_temp_sel) |-> ##[0:2] o_conv_busy)
    else $error("setup changed without a conversion");
endmodule : psc_top_asserts

bind psc_top psc_top_asserts #(.CONV_BASE_CYC(CONV_BASE_CYC)) u_chk (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_select_pin(i_select_pin),
  .i_protocol_select_pin(i_protocol_select_pin), .o_serial_out_oe(o_serial_out_oe),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_conv_busy(o_conv_busy),
  .o_conv_temp_sel(o_conv_temp_sel), .o_oversampling_ratio(o_oversampling_ratio)
);

// [test/psc_host_model.sv]
`timescale 1ns/1ps

module psc_host_model (
  // Serial pins toward the device
  output logic      o_sclk,
  output logic      o_select_pin,
  output logic      o_sdi,
  input  wire logic i_sdo,
  // Two-wire data line: host drive and wired-AND level seen on the bus
  output logic      o_sda,
  input  wire logic i_sda_line
);
  // Idle: deselected, clock still, data line not yet meaningful
  initial begin
    o_sclk = 1'b0;
    o_select_pin = 1'b1;
    o_sdi = 1'b1;
    o_sda = 1'b1;
  end

  // One two-wire bit: data set in the low phase, line sampled mid high phase
  task automatic i2c_bit(input logic b, output logic seen);
    o_sda = b;
    #150;
    o_sclk = 1'b1;
    #80;
    seen = i_sda_line;
    #80;
    o_sclk = 1'b0;
  endtask : i2c_bit

  task automatic i2c_start();
    o_sda = 1'b1;
    o_sclk = 1'b1;
    #150;
    o_sda = 1'b0;
    #150;
    o_sclk = 1'b0;
  endtask : i2c_start

  task automatic i2c_stop();
    o_sda = 1'b0;
    #150;
    o_sclk = 1'b1;
    #150;
    o_sda = 1'b1;
    #150;
  endtask : i2c_stop

  // Eight bits out or in, then the acknowledge slot
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                          output logic ack);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(tx[i], rx[i]);
    end
    i2c_bit(ack_in, ack);
  endtask : i2c_byte

  // Write transaction with one command byte; ok when both bytes are acknowledged
  task automatic i2c_write(input logic [7:0] cmd, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    i2c_start();
    i2c_byte(8'hEC, 1'b1, rx, a0);
    i2c_byte(cmd, 1'b1, rx, a1);
    i2c_stop();
    ok = ~a0 & ~a1;
  endtask : i2c_write

  // Read transaction: three bytes, host acknowledges all but the last
  task automatic i2c_read(output logic [23:0] data);
    logic [7:0] rx;
    logic       a;
    i2c_start();
    i2c_byte(8'hED, 1'b1, rx, a);
    i2c_byte(8'hFF, 1'b0, data[23:16], a);
    i2c_byte(8'hFF, 1'b0, data[15:8], a);
    i2c_byte(8'hFF, 1'b1, data[7:0], a);
    i2c_stop();
  endtask : i2c_read

  // One frame: a single command byte, then 24 clocks of answer
  task automatic xfer(input logic [7:0] cmd, input logic m3, output logic [23:0] resp);
    o_sclk = m3; // Idle level picks clock mode 0 or 3
    #7;
    o_select_pin = 1'b0;
    #5;
    for (int i = 0; i < 32; i++) begin
      o_sclk = 1'b0;
      o_sdi = (i < 8) ? cmd[7-i] : ~o_sdi;
      #3;
      if (i >= 8) resp[31-i] = i_sdo;
      o_sclk = 1'b1;
      #3;
    end
    o_sclk = m3;
    #3;
    o_select_pin = 1'b1;
    o_sdi = ~o_sdi; // Released line shows no stale value
    #100;
  endtask : xfer
endmodule : psc_host_model

// [test/test_pressure_sensor_command_port.sv]
`timescale 1ns/1ps

module test_pressure_sensor_command_port;
  localparam int BASE = 100;
  logic         i_sys_clk, i_resetn, sclk, sel_n, serial_in_pin, serial_out_pin, busy, tsel;
  logic         ps, hsda, sda_oe, ok;
  wire          sda_line = hsda & ~sda_oe;
  logic [2:0]   ratio;
  logic [7:0]   code;
  logic [23:0]  pres, temp, got;
  logic [127:0] cal;
  int           errors, comparisons;

  psc_host_model host (.o_sclk(sclk), .o_select_pin(sel_n), .o_sdi(serial_in_pin), .i_sdo(serial_out_pin),
                       .o_sda(hsda), .i_sda_line(sda_line));

  // Serial mode first, then two-wire; data line is a wired AND with pull-up
  psc_top #(.CONV_BASE_CYC(BASE)) uut (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_link_sclk(sclk),
    .i_select_pin(sel_n), .i_protocol_select_pin(ps), .i_serial_in_pin(serial_in_pin),
    .o_serial_out_pin(serial_out_pin), .o_serial_out_oe(), .i_sda(sda_line), .o_sda_out(),
    .o_sda_oe(sda_oe), .i_cal_image(cal), .i_raw_pressure_sample(pres),
    .i_raw_temperature_sample(temp), .o_conv_busy(busy),
    .o_conv_temp_sel(tsel), .o_oversampling_ratio(ratio)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Frame, then settle on the system clock before anything is looked at
  task automatic send(input logic [7:0] c, input logic m3);
    host.xfer(c, m3, got);
    @(negedge i_sys_clk);
  endtask : send

  task automatic rd(input logic [7:0] c, input logic m3, input string w, input logic [23:0] e);
    send(c, m3);
    check(w, e, got);
  endtask : rd

  // Bounded wait; a hang shows up as a busy mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(negedge i_sys_clk);
      n++;
    end
    check("busy end", 24'h0, {23'h0, busy});
  endtask : wait_idle

  task automatic summarize();
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    i_resetn = 1'b0;
    ps = 1'b0;
    errors = 0;
    comparisons = 0;
    cal = 128'h1A2B_3C4D_5E6F_7081_92A3_B4C5_D6E7_F809;
    pres = 24'h5A1C3E;
    temp = 24'h3C96A5;
    repeat (6) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    rd(8'hA6, 1'b0, "word before reload", 24'h0);
    send(8'h1E, 1'b1);
    for (int k = 0; k < 8; k++) begin
      rd(8'hA0 | 8'(k * 2), k[0], "cal word", {cal[16*k +: 16], 8'h00});
    end
    rd(8'h00, 1'b0, "no conversion", 24'h0);
    // Every pressure and temperature code, both clock modes
    for (int k = 0; k < 10; k++) begin
      code = 8'h40 + 8'((k % 5) * 2) + ((k >= 5) ? 8'h10 : 8'h00);
      send(code, k[0]);
      check("busy", 24'h1, {23'h0, busy});
      check("ratio", 24'(k % 5), {21'h0, ratio});
      check("temp sel", 24'(k >= 5), {23'h0, tsel});
      wait_idle();
      rd(8'h00, k[1], "result", (k >= 5) ? temp : pres);
      rd(8'h00, k[0], "repeat read", 24'h0);
    end
    // Read in mid conversion spoils that conversion
    send(8'h52, 1'b0);
    rd(8'h00, 1'b1, "read while busy", 24'h0);
    check("still busy", 24'h1, {23'h0, busy});
    wait_idle();
    rd(8'h00, 1'b0, "spoiled result", ~temp);
    // Reset command drops a finished, unread result
    send(8'h40, 1'b1);
    wait_idle();
    send(8'h1E, 1'b0);
    rd(8'h00, 1'b1, "after reset", 24'h0);
    // Undefined bytes change nothing
    send(8'h4A, 1'b0);
    send(8'hFF, 1'b1);
    check("undefined busy", 24'h0, {23'h0, busy});
    check("undefined ratio", 24'h0, {21'h0, ratio});
    rd(8'h00, 1'b0, "undefined read", 24'h0);
    // Two-wire mode: busy refusal, reset at any time, result and word reads
    ps = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    host.i2c_write(8'h48, ok);
    check("i2c conv ack", 24'h1, {23'h0, ok});
    host.i2c_write(8'h40, ok);
    check("i2c busy nack", 24'h0, {23'h0, ok});
    check("i2c still busy", 24'h1, {23'h0, busy});
    host.i2c_write(8'h1E, ok);
    check("i2c reset ack", 24'h1, {23'h0, ok});
    @(negedge i_sys_clk);
    check("i2c reset idle", 24'h0, {23'h0, busy});
    host.i2c_write(8'h50, ok);
    wait_idle();
    host.i2c_write(8'h00, ok);
    host.i2c_read(got);
    check("i2c result", temp, got);
    host.i2c_write(8'hA2, ok);
    host.i2c_read(got);
    check("i2c cal word", {cal[31:16], 8'h00}, got);
    summarize();
  end

  // Watchdog, far beyond the longest expected run
  initial begin
    #500000;
    errors++;
    summarize();
  end
endmodule : test_pressure_sensor_command_port
